/* File: bench/ims_cpu_model.sv */
// CPU core model that enters the service routine offered by the block
`timescale 1ns/10ps
module ims_cpu_model (
	input wire logic clk, // Clock
	input wire logic rst, // Synchronous reset, high
	input wire logic irq_req, // Serviceable request offered
	output logic isr_enter // Service entry pulse
);
	logic [1:0] gap_ff;
	logic [1:0] nxt_gap;

	// Hold off after an entry so one request is not entered twice
	assign nxt_gap = (irq_req && gap_ff == 2'h0) ? 2'h3 : (gap_ff == 2'h0 ? 2'h0 : gap_ff - 2'h1);

	// One-cycle entry pulse per offered request
	always_ff @(posedge clk) begin
		if (rst) begin
			isr_enter <= 1'b0;
			gap_ff <= 2'h0;
		end else begin
			isr_enter <= irq_req && gap_ff == 2'h0;
			gap_ff <= nxt_gap;
		end
	end
endmodule : ims_cpu_model

/* File: bench/test_irq_map_ext_sense_lowpower.sv */
// Self-checking bench for the interrupt map and power-mode block
`timescale 1ns/10ps
module test_irq_map_ext_sense_lowpower;
	typedef struct packed {logic [1:0] code; logic fall; logic rise;} ims_row_t;
	typedef struct packed {ims_pkg::ims_halt_t mode; logic [13:0] src; logic wk;} ims_wrow_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	ims_pkg::ims_wb_req_t req = '0;
	ims_pkg::ims_instr_t instr = '0;
	ims_pkg::ims_halt_t halt = ims_pkg::IMS_HLT_NONE;
	logic ack, irq_req, stopped, wake, ctick, ptick, enter;
	logic [31:0] rdat, rd;
	logic [7:0] pa = 8'hFF;
	logic [13:0] pirq = 14'h0000;
	logic [3:0] num;
	logic [15:0] vec;
	logic [1:0] level;
	logic [2:0] pend;
	int errors = 0;
	int tests_run = 0;
	int c, p;
	ims_row_t rows [3] = '{'{2'h1, 1'b0, 1'b1}, '{2'h2, 1'b1, 1'b0}, '{2'h3, 1'b1, 1'b1}};
	ims_wrow_t wrows [4] = '{'{ims_pkg::IMS_HLT_FULL, 14'h0001, 1'b0},
		'{ims_pkg::IMS_HLT_AWU, 14'h0001, 1'b1},
		'{ims_pkg::IMS_HLT_FULL, 14'h0080, 1'b0},
		'{ims_pkg::IMS_HLT_ACTIVE, 14'h0080, 1'b1}};

	// Clock at 25 MHz
	always #20 clk = ~clk;

	ims_top ims_top_i (.CLK(clk), .RST(rst), .WB_REQ(req), .WB_ACK(ack), .WB_DAT_O(rdat),
		.PORT_A_PINS(pa), .PORT_B_PINS(8'hFF), .PORT_C_PINS(8'hFF), .PERIPH_IRQ(pirq),
		.SW_PRIO(28'hFFFFFFF), .CPU_INSTR(instr), .CPU_ISR_ENTER(enter), .HALT_MODE(halt),
		.IRQ_REQ(irq_req), .IRQ_NUM(num), .IRQ_VECTOR(vec), .CUR_LEVEL(level),
		.CPU_STOPPED(stopped), .WAKE_REQ(wake), .CPU_CLK_TICK(ctick),
		.PERIPH_CLK_TICK(ptick), .EXT_PENDING(pend));
	ims_cpu_model ims_cpu_model_i (.clk(clk), .rst(rst), .irq_req(irq_req), .isr_enter(enter));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic close_out;
		if (errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Classic single Wishbone cycle, waits for ack
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge clk) req <= ims_pkg::ims_wb_req_t'{1'b1, 1'b1, we, adr, 4'hF, dat};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) errors++;
		rd = rdat;
		req <= '0;
		@(negedge clk);
	endtask : wb

	task automatic op(input ims_pkg::ims_op_t o, input logic [1:0] pl);
		@(posedge clk) instr <= ims_pkg::ims_instr_t'{1'b1, o, pl};
		@(posedge clk) instr <= '0;
		@(negedge clk);
	endtask : op

	task automatic wait_irq;
		int n;
		n = 0;
		while (irq_req !== 1'b1 && n < 80) begin
			@(negedge clk);
			n++;
		end
	endtask : wait_irq

	task automatic ticks(input int n);
		c = 0;
		p = 0;
		repeat (n) begin
			@(negedge clk);
			c += (ctick === 1'b1);
			p += (ptick === 1'b1);
		end
	endtask : ticks

	// ------------------------------------------------------------
	// Watchdog and main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		close_out();
	end

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("level", 32'h3, level);
		chk("stopped", 32'h0, stopped);
		ticks(32);
		chk("run cpu ticks", 32'h20, c);
		chk("run periph ticks", 32'h20, p);
		wb(1'b0, ims_pkg::IMS_OFF_SENSE, 32'h0);
		chk("sense reset", 32'h0, rd);
		wb(1'b1, ims_pkg::IMS_OFF_SENSE, 32'hFF);
		wb(1'b0, ims_pkg::IMS_OFF_SENSE, 32'h0);
		chk("sense reserved", 32'h3F, rd);
		wb(1'b0, 4'h2, 32'h0);
		chk("unmapped", 32'h0, rd);
		wb(1'b1, ims_pkg::IMS_OFF_PINEN, 32'h010103);
		// Port A sensitivity codes: falling, clearing by change, rising
		foreach (rows[i]) begin
			wb(1'b1, ims_pkg::IMS_OFF_SENSE, {30'h0, ~rows[i].code});
			wb(1'b1, ims_pkg::IMS_OFF_SENSE, {30'h0, rows[i].code});
			@(posedge clk) pa <= 8'hFC;
			repeat (3) @(negedge clk);
			chk("fall latch", rows[i].fall, pend[0]);
			wb(1'b1, ims_pkg::IMS_OFF_SENSE, {30'h0, ~rows[i].code});
			chk("cleared", 32'h0, pend[0]);
			wb(1'b1, ims_pkg::IMS_OFF_SENSE, {30'h0, rows[i].code});
			@(posedge clk) pa <= 8'hFF;
			repeat (3) @(negedge clk);
			chk("rise latch", rows[i].rise, pend[0]);
		end
		wb(1'b1, ims_pkg::IMS_OFF_SENSE, 32'h2);
		op(ims_pkg::IMS_OP_RIM, 2'h0);
		chk("rim level", 32'h2, level);
		wb(1'b1, ims_pkg::IMS_OFF_SENSE, 32'h3F);
		wb(1'b0, ims_pkg::IMS_OFF_SENSE, 32'h0);
		chk("sense locked", 32'h2, rd);
		op(ims_pkg::IMS_OP_HALT, 2'h0);
		chk("halt level", 32'h2, level);
		op(ims_pkg::IMS_OP_POP_CONDITION_CODE_INSTR, 2'h1);
		chk("pop level", 32'h1, level);
		op(ims_pkg::IMS_OP_INTERRUPT_RETURN_INSTR, 2'h0);
		chk("interrupt_return_instr level", 32'h0, level);
		op(ims_pkg::IMS_OP_SIM, 2'h0);
		chk("sim level", 32'h3, level);
		// Both enabled pins fall while masked, then wait opens the mask
		@(posedge clk) pa <= 8'hFC;
		repeat (3) @(negedge clk);
		chk("masked pending", 32'h1, {irq_req, pend[0]});
		op(ims_pkg::IMS_OP_WFI, 2'h0);
		chk("wait entry", 32'h5, {stopped, ctick, ptick});
		chk("wait level", 32'h2, level);
		wait_irq();
		chk("port A vector", 32'h2FFF6, {num, vec});
		repeat (4) @(negedge clk);
		chk("woken", 32'h0, {stopped, pend[0]});
		chk("entry level", 32'h3, level);
		@(posedge clk) pa <= 8'hFF;
		@(posedge clk) pa <= 8'hFC;
		wb(1'b1, ims_pkg::IMS_OFF_CLKCTL, 32'h2);
		op(ims_pkg::IMS_OP_RIM, 2'h0);
		wait_irq();
		chk("variant two vector", 32'h4FFF2, {num, vec});
		repeat (4) @(negedge clk);
		// Slow mode, then slow-wait, woken by the auto-wakeup source
		wb(1'b1, ims_pkg::IMS_OFF_CLKCTL, 32'h1);
		ticks(64);
		chk("slow ticks", 32'h202, {c[15:0], p[7:0]});
		op(ims_pkg::IMS_OP_WFI, 2'h0);
		ticks(64);
		chk("slow wait ticks", 32'h002, {c[15:0], p[7:0]});
		wb(1'b0, ims_pkg::IMS_OFF_STATUS, 32'h0);
		chk("slow wait mode", 32'h3, rd[3:0]);
		@(posedge clk) pirq <= 14'h0001;
		wait_irq();
		chk("wakeup vector", 32'h0FFFA, {num, vec});
		repeat (8) @(negedge clk);
		@(posedge clk) pirq <= 14'h0000;
		// Wakeup capability per halt kind, with the mask set
		foreach (wrows[i]) begin
			@(posedge clk) begin
				pirq <= wrows[i].src;
				halt <= wrows[i].mode;
			end
			repeat (3) @(negedge clk);
			chk("wake", wrows[i].wk, wake);
		end
		close_out();
	end
endmodule : test_irq_map_ext_sense_lowpower

/* File: design/ims_pkg.sv */
// Constants, types and helpers shared by the interrupt map and power-mode block
package ims_pkg;

	// ------------------------------------------------------------
	// Register map (byte offsets)
	// ------------------------------------------------------------
	localparam logic [3:0] IMS_OFF_SENSE = 4'h0;
	localparam logic [3:0] IMS_OFF_CLKCTL = 4'h4;
	localparam logic [3:0] IMS_OFF_STATUS = 4'h8;
	localparam logic [3:0] IMS_OFF_PINEN = 4'hC;

	// ------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] IMS_SENSE_RST = 8'h00;
	localparam logic [5:0] IMS_SENSE_WMASK = 6'h3F;
	localparam int IMS_SMS_BIT = 0;
	localparam int IMS_VAR_BIT = 1;
	localparam logic [23:0] IMS_PINEN_RST = 24'h000000;
	localparam logic [1:0] IMS_LVL_RST = 2'h3;
	localparam logic [1:0] IMS_LVL_MAIN = 2'h2;
	localparam logic [1:0] IMS_LVL_OFF = 2'h3;

	// ------------------------------------------------------------
	// Sensitivity codes
	// ------------------------------------------------------------
	localparam logic [1:0] IMS_SNS_FALL_LOW = 2'h0;
	localparam logic [1:0] IMS_SNS_RISE = 2'h1;
	localparam logic [1:0] IMS_SNS_FALL = 2'h2;
	localparam logic [1:0] IMS_SNS_BOTH = 2'h3;

	// ------------------------------------------------------------
	// Vector map
	// ------------------------------------------------------------
	localparam int IMS_NVEC = 14;
	localparam logic [15:0] IMS_VEC_TOP = 16'hFFFA;
	localparam logic [3:0] IMS_V1_EXT_BASE = 4'h2;
	localparam logic [3:0] IMS_V2_EXT_BASE = 4'h4;
	localparam logic [13:0] IMS_V1_USED = 14'h1FFD;
	localparam logic [13:0] IMS_V2_USED = 14'h3FF1;
	localparam logic [13:0] IMS_V1_WK_HALT = 14'h001C;
	localparam logic [13:0] IMS_V1_WK_AWU = 14'h001D;
	localparam logic [13:0] IMS_V1_WK_ACT = 14'h049C;
	localparam logic [13:0] IMS_V2_WK_HALT = 14'h0070;
	localparam logic [13:0] IMS_V2_WK_AWU = 14'h0071;
	localparam logic [13:0] IMS_V2_WK_ACT = 14'h2170;

	// ------------------------------------------------------------
	// Clock divider
	// ------------------------------------------------------------
	localparam int IMS_SLOW_DIV = 32;
	localparam logic [4:0] IMS_DIV_LAST = 5'(IMS_SLOW_DIV - 1);

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		IMS_OP_NONE, IMS_OP_HALT, IMS_OP_POP_CONDITION_CODE_INSTR, IMS_OP_RIM,
		IMS_OP_SIM, IMS_OP_WFI, IMS_OP_INTERRUPT_RETURN_INSTR
	} ims_op_t;

	typedef enum logic [1:0] {
		IMS_HLT_NONE, IMS_HLT_FULL, IMS_HLT_ACTIVE, IMS_HLT_AWU
	} ims_halt_t;

	typedef struct packed {
		logic valid;
		ims_op_t op;
		logic [1:0] pop_level;
	} ims_instr_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} ims_wb_req_t;

	// Priority rank: level 10 lowest, then 01, 00, 11 highest
	function automatic logic [1:0] ims_rank(input logic [1:0] code);
		case (code)
			2'h2: ims_rank = 2'h0;
			2'h1: ims_rank = 2'h1;
			2'h0: ims_rank = 2'h2;
			default: ims_rank = 2'h3;
		endcase
	endfunction : ims_rank

endpackage : ims_pkg

/* File: design/ims_top.sv */
// Interrupt vector map, external sensitivity and slow/wait power modes
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/10ps
module ims_top (
	input wire logic CLK, // 25 MHz clock
	input wire logic RST, // Synchronous reset, high
	input wire ims_pkg::ims_wb_req_t WB_REQ, // Wishbone request group
	output logic WB_ACK, // Wishbone acknowledge
	output logic [31:0] WB_DAT_O, // Wishbone read data
	input wire logic [7:0] PORT_A_PINS, // Port A pin levels
	input wire logic [7:0] PORT_B_PINS, // Port B pin levels
	input wire logic [7:0] PORT_C_PINS, // Port C pin levels
	input wire logic [13:0] PERIPH_IRQ, // Peripheral requests by vector
	input wire logic [27:0] SW_PRIO, // Software priority per vector
	input wire ims_pkg::ims_instr_t CPU_INSTR, // Executed instruction
	input wire logic CPU_ISR_ENTER, // Service routine entry pulse
	input wire ims_pkg::ims_halt_t HALT_MODE, // Current halt state
	output logic IRQ_REQ, // Serviceable request present
	output logic [3:0] IRQ_NUM, // Selected vector number
	output logic [15:0] IRQ_VECTOR, // Selected vector address
	output logic [1:0] CUR_LEVEL, // Current software priority
	output logic CPU_STOPPED, // CPU halted by wait
	output logic WAKE_REQ, // Wakeup from current halt
	output logic CPU_CLK_TICK, // CPU clock enable pulse
	output logic PERIPH_CLK_TICK, // Peripheral clock enable pulse
	output logic [2:0] EXT_PENDING // Port C, B, A pending
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	typedef enum {S_RUN, S_SLOW, S_WAIT, S_SLOW_WAIT} ims_mode_t;
	ims_mode_t mode_ff, nxt_mode;
	logic [5:0] sense_ff;
	logic [1:0] clkctl_ff;
	logic [23:0] pinen_ff;
	logic [1:0] level_ff, nxt_level;
	logic [2:0] line_prev_ff, latch_ff;
	logic [4:0] div_ff;
	logic ack_ff, irq_req_ff, stopped_ff, wake_ff, cpu_tick_ff, per_tick_ff;
	logic [3:0] irq_num_ff;
	logic [15:0] irq_vec_ff;
	logic [31:0] rdat_ff;
	logic [2:0] line_now, ext_req, sense_chg, ext_svc, ext_set;
	logic [13:0] req_vec, serviceable, used_mask, wk_mask;
	logic [3:0] ext_base, sel_num;
	logic sel_any, bus_go, wr_go, sense_wr_ok, slow_sel, var_two;
	logic div_wrap, stopped_now;
	logic [5:0] sense_new;
	logic [31:0] rdat_mux;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	// Answer one cycle after the request; write lands on the ack edge
	assign bus_go = WB_REQ.cyc & WB_REQ.stb & ~ack_ff;
	assign wr_go = WB_REQ.cyc & WB_REQ.stb & WB_REQ.we & ack_ff;
	assign sense_wr_ok = wr_go & (WB_REQ.adr == ims_pkg::IMS_OFF_SENSE) & WB_REQ.sel[0]
		& (level_ff == ims_pkg::IMS_LVL_OFF);
	assign sense_new = WB_REQ.dat[5:0] & ims_pkg::IMS_SENSE_WMASK;
	assign slow_sel = clkctl_ff[ims_pkg::IMS_SMS_BIT];
	assign var_two = clkctl_ff[ims_pkg::IMS_VAR_BIT];

	// Read data selection; unmapped offsets read zero
	assign rdat_mux = (WB_REQ.adr == ims_pkg::IMS_OFF_SENSE) ? {26'h0, sense_ff} :
		(WB_REQ.adr == ims_pkg::IMS_OFF_CLKCTL) ? {30'h0, clkctl_ff} :
		(WB_REQ.adr == ims_pkg::IMS_OFF_STATUS) ?
			{16'h0, irq_num_ff, 1'b0, latch_ff, level_ff, 4'(mode_ff)} :
		(WB_REQ.adr == ims_pkg::IMS_OFF_PINEN) ? {8'h0, pinen_ff} : 32'h0;

	// Bus acknowledge and read data
	always_ff @(posedge CLK) begin
		if (RST) begin
			ack_ff <= 1'b0;
			rdat_ff <= 32'h0;
		end else begin
			ack_ff <= bus_go;
			rdat_ff <= bus_go ? rdat_mux : 32'h0;
		end
	end

	// Software registers
	always_ff @(posedge CLK) begin
		if (RST) begin
			sense_ff <= ims_pkg::IMS_SENSE_RST[5:0];
			clkctl_ff <= 2'h0;
			pinen_ff <= ims_pkg::IMS_PINEN_RST;
		end else begin
			if (sense_wr_ok) sense_ff <= sense_new;
			if (wr_go && WB_REQ.adr == ims_pkg::IMS_OFF_CLKCTL && WB_REQ.sel[0])
				clkctl_ff <= WB_REQ.dat[1:0];
			if (wr_go && WB_REQ.adr == ims_pkg::IMS_OFF_PINEN) begin
				if (WB_REQ.sel[0]) pinen_ff[7:0] <= WB_REQ.dat[7:0];
				if (WB_REQ.sel[1]) pinen_ff[15:8] <= WB_REQ.dat[15:8];
				if (WB_REQ.sel[2]) pinen_ff[23:16] <= WB_REQ.dat[23:16];
			end
		end
	end

	// ------------------------------------------------------------
	// External interrupt lines
	// ------------------------------------------------------------
	// Enabled pins of a port are ORed onto one line
	assign line_now = {|(PORT_C_PINS & pinen_ff[23:16]), |(PORT_B_PINS & pinen_ff[15:8]),
		|(PORT_A_PINS & pinen_ff[7:0])};
	assign ext_base = var_two ? ims_pkg::IMS_V2_EXT_BASE : ims_pkg::IMS_V1_EXT_BASE;

	for (genvar k = 0; k < 3; k++) begin : g_ext
		logic [1:0] code;
		logic rise, fall;
		assign code = sense_ff[2*k +: 2];
		assign rise = line_now[k] & ~line_prev_ff[k];
		assign fall = ~line_now[k] & line_prev_ff[k];
		// Edge selection by sensitivity code
		assign ext_set[k] = (code == ims_pkg::IMS_SNS_RISE) ? rise :
			(code == ims_pkg::IMS_SNS_FALL) ? fall :
			(code == ims_pkg::IMS_SNS_BOTH) ? (rise | fall) : fall;
		assign sense_chg[k] = sense_wr_ok & (sense_new[2*k +: 2] != code);
		assign ext_svc[k] = CPU_ISR_ENTER & (irq_num_ff == ext_base + 4'(k));
		// Level-low code also requests while the line stays low
		assign ext_req[k] = latch_ff[k] |
			((code == ims_pkg::IMS_SNS_FALL_LOW) & ~line_now[k] & ~sense_chg[k]);
	end

	// Edge latches: a new edge wins over a clear in the same cycle
	always_ff @(posedge CLK) begin
		if (RST) begin
			line_prev_ff <= 3'h0;
			latch_ff <= 3'h0;
		end else begin
			line_prev_ff <= line_now;
			latch_ff <= ext_set | (latch_ff & ~ext_svc & ~sense_chg);
		end
	end

	// ------------------------------------------------------------
	// Vector map and arbitration
	// ------------------------------------------------------------
	assign used_mask = var_two ? ims_pkg::IMS_V2_USED : ims_pkg::IMS_V1_USED;

	// Place sources onto the vector slots of the selected variant
	always_comb begin
		req_vec = PERIPH_IRQ & used_mask;
		req_vec[ext_base +: 3] = ext_req;
		if (!var_two) req_vec[5] = PERIPH_IRQ[5];
	end

	// Higher software priority than the current level is required
	for (genvar v = 0; v < ims_pkg::IMS_NVEC; v++) begin : g_svc
		assign serviceable[v] = req_vec[v] &
			(ims_pkg::ims_rank(SW_PRIO[2*v +: 2]) > ims_pkg::ims_rank(level_ff));
	end

	// Lowest number wins the hardware priority
	always_comb begin
		sel_num = 4'h0;
		sel_any = 1'b0;
		for (int i = ims_pkg::IMS_NVEC - 1; i >= 0; i--) begin
			if (serviceable[i]) begin
				sel_num = 4'(i);
				sel_any = 1'b1;
			end
		end
	end

	// Wakeup capability per variant and halt flavour
	assign wk_mask = (HALT_MODE == ims_pkg::IMS_HLT_FULL) ?
			(var_two ? ims_pkg::IMS_V2_WK_HALT : ims_pkg::IMS_V1_WK_HALT) :
		(HALT_MODE == ims_pkg::IMS_HLT_AWU) ?
			(var_two ? ims_pkg::IMS_V2_WK_AWU : ims_pkg::IMS_V1_WK_AWU) :
		(HALT_MODE == ims_pkg::IMS_HLT_ACTIVE) ?
			(var_two ? ims_pkg::IMS_V2_WK_ACT : ims_pkg::IMS_V1_WK_ACT) : 14'h0;

	// Request outputs, vector address is top minus twice the number
	always_ff @(posedge CLK) begin
		if (RST) begin
			irq_req_ff <= 1'b0;
			irq_num_ff <= 4'h0;
			irq_vec_ff <= ims_pkg::IMS_VEC_TOP;
			wake_ff <= 1'b0;
		end else begin
			irq_req_ff <= sel_any;
			irq_num_ff <= sel_num;
			irq_vec_ff <= ims_pkg::IMS_VEC_TOP - {11'h0, sel_num, 1'b0};
			wake_ff <= |(req_vec & wk_mask);
		end
	end

	// ------------------------------------------------------------
	// Current software priority
	// ------------------------------------------------------------
	always_comb begin
		nxt_level = level_ff;
		if (CPU_ISR_ENTER) begin
			nxt_level = SW_PRIO[2*irq_num_ff +: 2];
		end else if (CPU_INSTR.valid) begin
			case (CPU_INSTR.op)
				ims_pkg::IMS_OP_HALT: nxt_level = ims_pkg::IMS_LVL_MAIN;
				ims_pkg::IMS_OP_WFI: nxt_level = ims_pkg::IMS_LVL_MAIN;
				ims_pkg::IMS_OP_RIM: nxt_level = ims_pkg::IMS_LVL_MAIN;
				ims_pkg::IMS_OP_SIM: nxt_level = ims_pkg::IMS_LVL_OFF;
				ims_pkg::IMS_OP_POP_CONDITION_CODE_INSTR: nxt_level = CPU_INSTR.pop_level;
				ims_pkg::IMS_OP_INTERRUPT_RETURN_INSTR: nxt_level = CPU_INSTR.pop_level;
				default: nxt_level = level_ff;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) level_ff <= ims_pkg::IMS_LVL_RST;
		else level_ff <= nxt_level;
	end

	// ------------------------------------------------------------
	// Power mode and clock division
	// ------------------------------------------------------------
	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			S_RUN: begin
				if (CPU_INSTR.valid && CPU_INSTR.op == ims_pkg::IMS_OP_WFI) nxt_mode = S_WAIT;
				else if (slow_sel) nxt_mode = S_SLOW;
			end
			S_SLOW: begin
				if (CPU_INSTR.valid && CPU_INSTR.op == ims_pkg::IMS_OP_WFI)
					nxt_mode = S_SLOW_WAIT;
				else if (!slow_sel) nxt_mode = S_RUN;
			end
			S_WAIT: if (sel_any) nxt_mode = S_RUN;
			S_SLOW_WAIT: if (sel_any) nxt_mode = S_SLOW;
			default: nxt_mode = S_RUN;
		endcase
	end

	assign div_wrap = (div_ff == ims_pkg::IMS_DIV_LAST);
	assign stopped_now = (nxt_mode == S_WAIT) || (nxt_mode == S_SLOW_WAIT);

	// Mode state, divider and clock enables
	always_ff @(posedge CLK) begin
		if (RST) begin
			mode_ff <= S_RUN;
			div_ff <= 5'h0;
			stopped_ff <= 1'b0;
			cpu_tick_ff <= 1'b0;
			per_tick_ff <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			div_ff <= div_ff + 5'h1;
			stopped_ff <= stopped_now;
			if (nxt_mode == S_SLOW || nxt_mode == S_SLOW_WAIT) begin
				per_tick_ff <= div_wrap;
				cpu_tick_ff <= div_wrap & ~stopped_now;
			end else begin
				per_tick_ff <= 1'b1;
				cpu_tick_ff <= ~stopped_now;
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign WB_ACK = ack_ff;
	assign WB_DAT_O = rdat_ff;
	assign IRQ_REQ = irq_req_ff;
	assign IRQ_NUM = irq_num_ff;
	assign IRQ_VECTOR = irq_vec_ff;
	assign CUR_LEVEL = level_ff;
	assign CPU_STOPPED = stopped_ff;
	assign WAKE_REQ = wake_ff;
	assign CPU_CLK_TICK = cpu_tick_ff;
	assign PERIPH_CLK_TICK = per_tick_ff;
	assign EXT_PENDING = latch_ff;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_wfi;
		CPU_INSTR.valid && CPU_INSTR.op == ims_pkg::IMS_OP_WFI && !CPU_ISR_ENTER;
	endsequence

	a_wait_unmask: assert property (@(posedge CLK) disable iff (RST)
		s_wfi |=> level_ff == ims_pkg::IMS_LVL_MAIN)
		else $error("wait did not enable interrupts");
	a_wait_stops: assert property (@(posedge CLK) disable iff (RST)
		s_wfi ##1 (mode_ff == S_WAIT || mode_ff == S_SLOW_WAIT) |-> CPU_STOPPED && !CPU_CLK_TICK)
		else $error("cpu not stopped in wait");
	a_slow_wait: assert property (@(posedge CLK) disable iff (RST)
		s_wfi and (mode_ff == S_SLOW) |=> mode_ff == S_SLOW_WAIT)
		else $error("slow-wait not entered");
	a_wait_exit: assert property (@(posedge CLK) disable iff (RST)
		mode_ff == S_WAIT && !sel_any |=> mode_ff == S_WAIT || RST)
		else $error("wait left without interrupt");
	a_slow_div: assert property (@(posedge CLK) disable iff (RST)
		mode_ff == S_SLOW && PERIPH_CLK_TICK && slow_sel |=> !PERIPH_CLK_TICK [*8])
		else $error("slow tick spacing wrong");
	a_sense_gate: assert property (@(posedge CLK) disable iff (RST)
		wr_go && WB_REQ.adr == ims_pkg::IMS_OFF_SENSE && level_ff != ims_pkg::IMS_LVL_OFF
		|=> $stable(sense_ff))
		else $error("sense written while unmasked");
	a_sense_resv: assert property (@(posedge CLK) disable iff (RST)
		ack_ff && !WB_REQ.we && WB_REQ.adr == ims_pkg::IMS_OFF_SENSE |-> WB_DAT_O[7:6] == 2'h0)
		else $error("reserved sense bits not zero");
	a_chg_clears: assert property (@(posedge CLK) disable iff (RST)
		sense_chg[0] && !ext_set[0] |=> !latch_ff[0])
		else $error("sense change kept pending");
	a_vec_addr: assert property (@(posedge CLK) disable iff (RST)
		IRQ_REQ && IRQ_NUM == 4'hD |-> IRQ_VECTOR == 16'hFFE0)
		else $error("vector address wrong");
	a_prio_hold: assert property (@(posedge CLK) disable iff (RST)
		level_ff == ims_pkg::IMS_LVL_OFF && $stable(level_ff) |=> !IRQ_REQ)
		else $error("request serviced at level three");
	a_awu_halt: assert property (@(posedge CLK) disable iff (RST)
		HALT_MODE == ims_pkg::IMS_HLT_FULL && req_vec == 14'h0001 |=> !WAKE_REQ)
		else $error("auto-wakeup woke plain halt");

endmodule : ims_top
